// >>> design/pls_pkg.sv
// Shared constants, types and helpers for the link speed and polarity logic
package pls_pkg;
    // Lanes bound to one port; a pair of ports merges into an eight-lane port
    localparam int LANES = 4;
    localparam int LANES_MERGED = 8;
    // Width reporting codes
    localparam logic [5:0] WIDTH_X1 = 6'h01;
    localparam logic [5:0] WIDTH_X4 = 6'h04;
    // Speed field encodings: 2.5 Gbps and 5.0 Gbps
    localparam logic [3:0] SPEED_GEN1 = 4'h1;
    localparam logic [3:0] SPEED_GEN2 = 4'h2;
    // Target speed after reset
    localparam logic [3:0] TARGET_SPEED_RST = SPEED_GEN2;
    // Link clock: toggles after four core cycles, so one period is eight cycles
    localparam logic [1:0] LINK_HALF_LAST = 2'h3;
    // Timing counts in link clock ticks
    localparam logic [8:0] TRAIN_LAST = 9'h17f;
    localparam logic [8:0] SPD_MIN = 9'h004;
    localparam logic [8:0] SPD_TIMEOUT_LAST = 9'h03f;
    // Training set symbols
    localparam logic [7:0] SYM_COM = 8'hbc;
    localparam logic [7:0] SYM_PAD = 8'h00;
    localparam logic [7:0] TS1_ID = 8'h4a;
    localparam logic [7:0] TS2_ID = 8'h45;
    localparam logic [3:0] POL_FIRST_SYM = 4'h6;

    // Port side training state
    typedef enum logic [3:0] {
        DS_DETECT = 4'b0001,
        DS_TRAIN = 4'b0010,
        DS_L0 = 4'b0100,
        DS_SPEED = 4'b1000
    } pls_dev_state_t;

    // What started a speed change
    typedef enum logic [3:0] {
        CS_INIT = 4'b0001,
        CS_SW = 4'b0010,
        CS_PEER = 4'b0100,
        CS_AUTO = 4'b1000
    } pls_cause_t;

    // Partner side state
    typedef enum logic [2:0] {
        PS_DOWN = 3'b001,
        PS_UP = 3'b010,
        PS_REQ = 3'b100
    } pls_ptr_state_t;

    // Partner pins as seen by the port
    typedef struct packed {
        logic up;
        logic spd_req;
        logic req_gen2;
        logic auto_chg;
        logic adv_gen2;
        logic rate_gen2;
        logic frame;
        logic [LANES-1:0] pos;
        logic [LANES-1:0] neg;
    } pls_ptr_bus_t;

    // Port pins as seen by the partner
    typedef struct packed {
        logic detect;
        logic l0;
        logic spd_req;
        logic req_gen2;
        logic adv_gen2;
        logic auto_chg;
    } pls_dev_bus_t;

    // Symbol sent at a given position of a training set
    function automatic logic [7:0] ts_symbol(input logic [3:0] idx);
        if (idx == 4'h0)
        begin
            return SYM_COM;
        end
        else if (idx < POL_FIRST_SYM)
        begin
            return SYM_PAD;
        end
        return TS1_ID;
    endfunction
endpackage

// >>> design/pls_link_if.sv
// Link between the switch port and its partner
interface pls_link_if;
    logic link_clk; // Made by the port
    logic dev_detect; // Port is in Detect
    logic dev_l0; // Port is in L0
    logic dev_spd_req; // Port runs a speed change
    logic dev_req_gen2; // Rate asked for by the port
    logic dev_adv_gen2; // Port advertises 5.0 Gbps
    logic dev_auto_chg; // Autonomous change bit sent by the port
    logic ptr_up; // Partner present and training
    logic ptr_spd_req; // Partner asks for a speed change
    logic ptr_req_gen2; // Rate asked for by the partner
    logic ptr_auto_chg; // Partner request is autonomous
    logic ptr_adv_gen2; // Partner advertises 5.0 Gbps
    logic ptr_rate_gen2; // Partner running at 5.0 Gbps
    logic rx_frame; // First bit of a training set
    logic [pls_pkg::LANES-1:0] rx_lane_pos; // Receive lanes, true leg
    logic [pls_pkg::LANES-1:0] rx_lane_neg; // Receive lanes, complement leg

    modport dev (
        output link_clk, dev_detect, dev_l0, dev_spd_req, dev_req_gen2, dev_adv_gen2, dev_auto_chg,
        input ptr_up, ptr_spd_req, ptr_req_gen2, ptr_auto_chg, ptr_adv_gen2, ptr_rate_gen2,
        input rx_frame, rx_lane_pos, rx_lane_neg
    );
    modport ptr (
        input link_clk, dev_detect, dev_l0, dev_spd_req, dev_req_gen2, dev_adv_gen2, dev_auto_chg,
        output ptr_up, ptr_spd_req, ptr_req_gen2, ptr_auto_chg, ptr_adv_gen2, ptr_rate_gen2,
        output rx_frame, rx_lane_pos, rx_lane_neg
    );
endinterface

// >>> design/pls_lane_pol.sv
// One receive lane: polarity detection on training sets and data correction
module pls_lane_pol (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic tick_in,
    input wire logic bit_in,
    input wire logic frame_in,
    input wire logic train_in,
    input wire logic clear_in,
    output logic inverted_out,
    output logic data_out
);
    import pls_pkg::*;

    // All lane state
    typedef struct packed {
        logic [7:0] sh; // Symbol shifter, first bit lands highest
        logic [2:0] bcnt; // Bit within symbol
        logic [3:0] scnt; // Symbol within training set
        logic inv; // Lane inverted
        logic dat; // Corrected bit
    } pls_lane_t;

    pls_lane_t r;
    pls_lane_t nx;

    // Next state
    always_comb
    begin
        logic [7:0] sym;
        sym = {r.sh[6:0], bit_in};
        nx = r;
        if (clear_in)
        begin
            nx.inv = 1'b0;
        end
        else if (tick_in)
        begin
            nx.sh = sym;
            nx.dat = bit_in ^ r.inv;
            if (frame_in)
            begin
                // Frame marks bit 0 of symbol 0
                nx.bcnt = 3'h1;
                nx.scnt = 4'h0;
            end
            else
            begin
                nx.bcnt = r.bcnt + 3'h1;
                if (r.bcnt == 3'h7)
                begin
                    nx.scnt = r.scnt + 4'h1;
                    // Symbols 6 up to 15 hold only the set identifier
                    if (train_in && r.scnt >= POL_FIRST_SYM)
                    begin
                        if (sym == ~TS1_ID || sym == ~TS2_ID)
                        begin
                            nx.inv = 1'b1;
                        end
                        else if (sym == TS1_ID || sym == TS2_ID)
                        begin
                            nx.inv = 1'b0;
                        end
                    end
                end
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= nx;
        end
    end

    assign inverted_out = r.inv;
    assign data_out = r.dat;
endmodule // pls_lane_pol

// >>> design/pls_dev_end.sv
// Switch downstream port: polarity per lane and Gen1/Gen2 speed negotiation
module pls_dev_end (
    input wire logic core_clk_in,
    input wire logic rst_in,
    pls_link_if.dev link,
    input wire logic target_speed_wr_in,
    input wire logic [3:0] target_speed_data_in,
    input wire logic cfg_load_in,
    input wire logic [3:0] cfg_target_speed_in,
    input wire logic retrain_request_bit_in,
    input wire logic bw_mgmt_irq_enable_in,
    input wire logic bw_flag_clear_in,
    input wire logic abw_flag_clear_in,
    output logic [3:0] target_speed_field_out,
    output logic [3:0] current_speed_field_out,
    output logic bw_mgmt_status_flag_out,
    output logic autonomous_bw_status_flag_out,
    output logic bw_notify_out,
    output logic full_retrain_out,
    output logic link_up_out,
    output logic [5:0] link_width_out,
    output logic [pls_pkg::LANES-1:0] lane_inverted_out,
    output logic [pls_pkg::LANES-1:0] rx_data_out
);
    import pls_pkg::*;

    // All port state
    typedef struct packed {
        logic [1:0] div; // Link clock divider
        logic lclk; // Link clock level
        pls_ptr_bus_t s1; // First sync stage, read only by s2
        pls_ptr_bus_t s2; // Second sync stage
        pls_dev_state_t st; // Training state
        logic [8:0] cnt; // Ticks in state
        logic rate2; // Running at 5.0 Gbps
        logic req2; // Rate asked for in a speed change
        pls_cause_t cause; // Origin of the running speed change
        logic [3:0] tgt; // Target speed field
        logic init_pend; // Automatic first upgrade still owed
        logic rtr; // Software retrain pending
        logic bw; // Bandwidth management flag
        logic abw; // Autonomous bandwidth flag
        logic notify; // Notification level
        logic full; // Full retrain pulse
        logic [5:0] width; // Reported width
    } pls_dev_t;

    pls_dev_t r;
    pls_dev_t nx;
    pls_ptr_bus_t pins; // Raw partner pins
    logic tick; // Link clock rising
    logic tgt_gen2; // Target asks for 5.0 Gbps
    logic [LANES-1:0] lane_inv; // Per-lane inversion
    logic [LANES-1:0] lane_dat; // Per-lane corrected data

    assign pins = '{up: link.ptr_up, spd_req: link.ptr_spd_req, req_gen2: link.ptr_req_gen2,
                    auto_chg: link.ptr_auto_chg, adv_gen2: link.ptr_adv_gen2,
                    rate_gen2: link.ptr_rate_gen2, frame: link.rx_frame,
                    pos: link.rx_lane_pos, neg: link.rx_lane_neg};
    assign tick = (r.div == LINK_HALF_LAST) && !r.lclk;
    assign tgt_gen2 = (r.tgt == SPEED_GEN2);

    // Lanes sample only while the pair is driven apart; equal legs mean idle
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        pls_lane_pol u_lane (
            .core_clk_in(core_clk_in),
            .rst_in(rst_in),
            .tick_in(tick && (r.s2.pos[i] ^ r.s2.neg[i])),
            .bit_in(r.s2.pos[i]),
            .frame_in(r.s2.frame),
            .train_in(r.st == DS_TRAIN),
            .clear_in(r.st == DS_DETECT),
            .inverted_out(lane_inv[i]),
            .data_out(lane_dat[i])
        );
    end

    // Next state
    always_comb
    begin
        logic bw_set;
        logic abw_set;
        bw_set = 1'b0;
        abw_set = 1'b0;
        nx = r;
        nx.s1 = pins;
        nx.s2 = r.s1;
        nx.full = 1'b0;
        nx.div = r.div + 2'h1;
        if (r.div == LINK_HALF_LAST)
        begin
            nx.lclk = ~r.lclk;
        end
        // Serial load wins over a software write in the same cycle
        if (cfg_load_in)
        begin
            nx.tgt = cfg_target_speed_in;
        end
        else if (target_speed_wr_in)
        begin
            nx.tgt = target_speed_data_in;
        end
        if (tick)
        begin
            nx.cnt = r.cnt + 9'h001;
            unique case (r.st)
                DS_DETECT:
                begin
                    // Every full training restarts at 2.5 Gbps
                    nx.rate2 = 1'b0;
                    nx.init_pend = 1'b1;
                    nx.cnt = 9'h000;
                    if (r.s2.up)
                    begin
                        nx.st = DS_TRAIN;
                        nx.full = 1'b1;
                    end
                end
                DS_TRAIN:
                begin
                    if (!r.s2.up)
                    begin
                        nx.st = DS_DETECT;
                    end
                    else if (r.cnt == TRAIN_LAST)
                    begin
                        nx.st = DS_L0;
                        nx.cnt = 9'h000;
                    end
                end
                DS_L0:
                begin
                    nx.cnt = 9'h000;
                    if (!r.s2.up)
                    begin
                        nx.st = DS_DETECT;
                    end
                    else if (r.s2.spd_req)
                    begin
                        // Partner requests are honoured even after a failed upgrade
                        nx.st = DS_SPEED;
                        nx.req2 = r.s2.req_gen2 && tgt_gen2;
                        nx.cause = r.s2.auto_chg ? CS_AUTO : CS_PEER;
                    end
                    else if (r.rtr)
                    begin
                        // Directed change, taken on a pending software retrain request
                        nx.st = DS_SPEED;
                        nx.rtr = 1'b0;
                        nx.req2 = tgt_gen2 && r.s2.adv_gen2;
                        nx.cause = CS_SW;
                    end
                    else if (r.init_pend && tgt_gen2 && r.s2.adv_gen2 && !r.rate2)
                    begin
                        // One automatic attempt per full training, no retry
                        nx.st = DS_SPEED;
                        nx.init_pend = 1'b0;
                        nx.req2 = 1'b1;
                        nx.cause = CS_INIT;
                    end
                end
                DS_SPEED:
                begin
                    if (!r.s2.up)
                    begin
                        nx.st = DS_DETECT;
                    end
                    else if (r.s2.rate_gen2 == r.req2 && r.cnt >= SPD_MIN)
                    begin
                        // Minimum dwell lets the partner see the request
                        nx.st = DS_L0;
                        nx.rate2 = r.req2;
                        if (r.req2 != r.rate2)
                        begin
                            bw_set = (r.cause == CS_SW) || (r.cause == CS_PEER);
                            abw_set = (r.cause == CS_AUTO);
                            // CS_INIT sets neither flag
                        end
                    end
                    else if (r.cnt == SPD_TIMEOUT_LAST)
                    begin
                        // Partner never matched: keep the prior rate
                        nx.st = DS_L0;
                    end
                end
            endcase
        end
        if (retrain_request_bit_in)
        begin
            nx.rtr = 1'b1;
        end
        // Hardware set wins over a clear in the same cycle
        nx.bw = bw_set || (r.bw && !bw_flag_clear_in);
        nx.abw = abw_set || (r.abw && !abw_flag_clear_in);
        nx.notify = nx.bw && bw_mgmt_irq_enable_in;
        nx.width = (nx.st == DS_L0 || nx.st == DS_SPEED) ? WIDTH_X4 : WIDTH_X1;
    end

    // State register
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r <= '{st: DS_DETECT, cause: CS_INIT, tgt: TARGET_SPEED_RST, width: WIDTH_X1,
                   default: '0};
        end
        else
        begin
            r <= nx;
        end
    end

    // Link side; no transmit lane path exists, so nothing is ever inverted outbound
    assign link.link_clk = r.lclk;
    assign link.dev_detect = (r.st == DS_DETECT);
    assign link.dev_l0 = (r.st == DS_L0);
    assign link.dev_spd_req = (r.st == DS_SPEED);
    assign link.dev_req_gen2 = r.req2;
    assign link.dev_adv_gen2 = tgt_gen2;
    assign link.dev_auto_chg = 1'b0;

    // User side
    assign target_speed_field_out = r.tgt;
    assign current_speed_field_out = r.rate2 ? SPEED_GEN2 : SPEED_GEN1;
    assign bw_mgmt_status_flag_out = r.bw;
    assign autonomous_bw_status_flag_out = r.abw;
    assign bw_notify_out = r.notify;
    assign full_retrain_out = r.full;
    assign link_up_out = (r.st == DS_L0) || (r.st == DS_SPEED);
    assign link_width_out = r.width;
    assign lane_inverted_out = lane_inv;
    assign rx_data_out = lane_dat;
endmodule // pls_dev_end

// >>> design/pls_ptr_end.sv
// Link partner end: sends training sets, answers and requests speed changes
module pls_ptr_end (
    input wire logic core_clk_in,
    input wire logic rst_in,
    pls_link_if.ptr link,
    input wire logic present_in,
    input wire logic adv_gen2_in,
    input wire logic accept_gen2_in,
    input wire logic req_in,
    input wire logic req_gen2_in,
    input wire logic req_auto_in,
    input wire logic [pls_pkg::LANES-1:0] invert_lane_in,
    output logic rate_gen2_out,
    output logic link_up_out,
    output logic dev_autonomous_out
);
    import pls_pkg::*;

    // All partner state
    typedef struct packed {
        logic c1; // Link clock sync, first stage
        logic c2; // Link clock sync, second stage
        logic cprev; // Previous synced clock
        pls_dev_bus_t d1; // Port pins, first stage
        pls_dev_bus_t d2; // Port pins, second stage
        pls_ptr_state_t st;
        logic [6:0] bpos; // Bit within training set
        logic rate2;
        logic pend; // Own request waiting
        logic req2;
        logic autoq;
        logic adv;
        logic frame;
        logic [LANES-1:0] pos;
        logic [LANES-1:0] neg;
        logic dauto;
    } pls_ptr_t;

    pls_ptr_t r;
    pls_ptr_t nx;
    pls_dev_bus_t dpins;

    assign dpins = '{detect: link.dev_detect, l0: link.dev_l0, spd_req: link.dev_spd_req,
                     req_gen2: link.dev_req_gen2, adv_gen2: link.dev_adv_gen2,
                     auto_chg: link.dev_auto_chg};

    // Next state, advancing once per link clock rising edge
    always_comb
    begin
        logic [7:0] sym;
        logic lane_bit;
        sym = ts_symbol(r.bpos[6:3]);
        lane_bit = sym[3'h7 - r.bpos[2:0]];
        nx = r;
        nx.c1 = link.link_clk;
        nx.c2 = r.c1;
        nx.cprev = r.c2;
        nx.d1 = dpins;
        nx.d2 = r.d1;
        if (r.c2 && !r.cprev)
        begin
            nx.bpos = r.bpos + 7'h01;
            nx.frame = (r.bpos == 7'h00);
            nx.pos = {LANES{lane_bit}} ^ invert_lane_in;
            nx.neg = ~nx.pos;
            nx.adv = adv_gen2_in;
            nx.dauto = r.d2.auto_chg;
            if (!present_in)
            begin
                nx.st = PS_DOWN;
                nx.rate2 = 1'b0;
                nx.pos = '0;
                nx.neg = '0;
            end
            else if (r.st == PS_DOWN)
            begin
                nx.st = PS_UP;
            end
            else if (r.d2.detect)
            begin
                nx.st = PS_UP;
                nx.rate2 = 1'b0;
            end
            else if (r.d2.spd_req)
            begin
                // Follow the port's rate; refusing 5.0 leaves the port to time out
                if (!r.d2.req_gen2 || (adv_gen2_in && accept_gen2_in))
                begin
                    nx.rate2 = r.d2.req_gen2;
                end
                if (r.st == PS_REQ)
                begin
                    nx.st = PS_UP;
                    nx.pend = 1'b0;
                end
            end
            else if (r.st == PS_UP && r.pend && r.d2.l0 && (!r.req2 || r.d2.adv_gen2))
            begin
                nx.st = PS_REQ;
            end
        end
        if (req_in)
        begin
            nx.pend = 1'b1;
            nx.req2 = req_gen2_in;
            nx.autoq = req_auto_in;
        end
    end

    // State register
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r <= '{st: PS_DOWN, default: '0};
        end
        else
        begin
            r <= nx;
        end
    end

    assign link.ptr_up = (r.st != PS_DOWN);
    assign link.ptr_spd_req = (r.st == PS_REQ);
    assign link.ptr_req_gen2 = r.req2;
    assign link.ptr_auto_chg = r.autoq && (r.st == PS_REQ);
    assign link.ptr_adv_gen2 = r.adv;
    assign link.ptr_rate_gen2 = r.rate2;
    assign link.rx_frame = r.frame;
    assign link.rx_lane_pos = r.pos;
    assign link.rx_lane_neg = r.neg;
    assign rate_gen2_out = r.rate2;
    assign link_up_out = (r.st != PS_DOWN);
    assign dev_autonomous_out = r.dauto;
endmodule // pls_ptr_end

// >>> sim/pls_link_props.sv
// Link-side assertions for the speed and polarity link
module pls_link_props (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic link_clk,
    input wire logic dev_detect,
    input wire logic dev_l0,
    input wire logic dev_spd_req,
    input wire logic dev_req_gen2,
    input wire logic dev_adv_gen2,
    input wire logic dev_auto_chg,
    input wire logic ptr_up
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] age_reg; // Cycles since partner last absent; saturates so it never wraps
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // Age of partner presence, cleared while absent
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            age_reg <= 5'h00;
        else if (!ptr_up)
            age_reg <= 5'h00;
        else if (age_reg != 5'h1f)
            age_reg <= age_reg + 5'h01;
    end
    sequence spd_hold_s;
        dev_spd_req [*8];
    endsequence
    sequence spd_done_s;
        ##[1:600] !dev_spd_req;
    endsequence
    link_clk_a: assert property ($rose(link_clk) |-> link_clk [*4] ##1 !link_clk [*4])
        else $error("link clock shape wrong");
    auto_bit_a: assert property (!dev_auto_chg)
        else $error("autonomous bit sent");
    train_gen1_a: assert property ($fell(dev_detect) |-> !dev_spd_req [*8])
        else $error("speed change during training");
    from_l0_a: assert property ($rose(dev_spd_req) |-> $past(dev_l0))
        else $error("speed change not from L0");
    spd_bound_a: assert property ($rose(dev_spd_req) |-> spd_hold_s ##0 spd_done_s)
        else $error("speed change length wrong");
    ask_gen2_a: assert property (dev_spd_req && dev_req_gen2 |-> dev_adv_gen2)
        else $error("asked 5.0 without target");
    no_down_a: assert property ($rose(dev_detect) |-> age_reg < 5'h10)
        else $error("link dropped with partner present");
    l0_excl_a: assert property (dev_l0 |-> !dev_detect && !dev_spd_req)
        else $error("state decode overlap");
endmodule // pls_link_props

// >>> sim/tb.sv
// Bench: port end and partner end joined over the link
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pls_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic sw_wr = 0, cfg_ld = 0, rtr = 0, irq_en = 0, bw_clr = 0, abw_clr = 0; // Port user side
    logic [3:0] sw_spd = 4'h0, cfg_spd = 4'h0, p_inv = 4'h0;
    logic pres = 0, p_acc = 1, p_adv = 1, p_req = 0, p_g2 = 0, p_auto = 0; // Partner user side
    logic [3:0] tgt, cur, inv, rxd;
    logic bwf, abwf, ntf, fr, up, p_rate, p_up, p_aut;
    logic [5:0] wid;
    int n_mismatch = 0, tests_run = 0, cyc = 0, n_fr = 0;
    pls_link_if lnk();
    pls_dev_end u_pls_dev_end (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(lnk),
        .target_speed_wr_in(sw_wr), .target_speed_data_in(sw_spd), .cfg_load_in(cfg_ld),
        .cfg_target_speed_in(cfg_spd), .retrain_request_bit_in(rtr), .bw_mgmt_irq_enable_in(irq_en),
        .bw_flag_clear_in(bw_clr), .abw_flag_clear_in(abw_clr), .target_speed_field_out(tgt),
        .current_speed_field_out(cur), .bw_mgmt_status_flag_out(bwf), .autonomous_bw_status_flag_out(abwf),
        .bw_notify_out(ntf), .full_retrain_out(fr), .link_up_out(up), .link_width_out(wid),
        .lane_inverted_out(inv), .rx_data_out(rxd));
    pls_ptr_end u_pls_ptr_end (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(lnk), .present_in(pres),
        .adv_gen2_in(p_adv), .accept_gen2_in(p_acc), .req_in(p_req), .req_gen2_in(p_g2), .req_auto_in(p_auto),
        .invert_lane_in(p_inv), .rate_gen2_out(p_rate), .link_up_out(p_up), .dev_autonomous_out(p_aut));
    pls_link_props u_pls_link_props (.core_clk_in(core_clk_in), .rst_in(rst_in), .link_clk(lnk.link_clk),
        .dev_detect(lnk.dev_detect), .dev_l0(lnk.dev_l0), .dev_spd_req(lnk.dev_spd_req),
        .dev_req_gen2(lnk.dev_req_gen2), .dev_adv_gen2(lnk.dev_adv_gen2), .dev_auto_chg(lnk.dev_auto_chg),
        .ptr_up(lnk.ptr_up));
    always #10 core_clk_in = ~core_clk_in;
    // Cycle ceiling and full retrain pulse count, sampled mid-cycle where the pulse stands
    always @(negedge core_clk_in)
    begin
        cyc++;
        n_fr += (fr === 1'b1);
        if (cyc == 60000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait for the reported rate
    task automatic wait_cur(input logic [3:0] v);
        for (int i = 0; i < 2000 && cur !== v; i++) @(negedge core_clk_in);
        repeat (2) @(negedge core_clk_in);
    endtask
    // Partner leaves and returns, forcing a pass through Detect
    task automatic link_cycle();
        pres = 0;
        repeat (40) @(negedge core_clk_in);
        chk(inv, 4'h0);
        pres = 1;
        for (int i = 0; i < 5000 && up !== 1'b1; i++) @(negedge core_clk_in);
        chk(cur, SPEED_GEN1);
    endtask
    // Software write of the target, then a retrain request
    task automatic sw_change(input logic [3:0] v);
        sw_spd = v;
        sw_wr = 1;
        @(negedge core_clk_in) sw_wr = 0;
        rtr = 1;
        @(negedge core_clk_in) rtr = 0;
        wait_cur(v);
        chk(cur, v);
        chk(bwf, 1);
        chk(ntf, irq_en);
        bw_clr = 1;
        @(negedge core_clk_in) bw_clr = 0;
    endtask
    task automatic t_boot();
        chk({tgt, cur}, {SPEED_GEN2, SPEED_GEN1});
        chk(wid, WIDTH_X1);
        p_inv = 4'h5;
        link_cycle();
        chk(n_fr, 1);
        chk(inv, 4'h5);
        chk(rxd == 4'h0 || rxd == 4'hf, 1);
        chk(wid, WIDTH_X4);
        wait_cur(SPEED_GEN2);
        chk({cur, bwf}, {SPEED_GEN2, 1'b0});
        chk(p_aut, 0);
        chk({p_up, p_rate}, 2'b11);
    endtask
    task automatic t_sw();
        irq_en = 1;
        sw_change(SPEED_GEN1);
        irq_en = 0;
        sw_change(SPEED_GEN2);
    endtask
    // Partner autonomous downgrade, then a partner upgrade
    task automatic t_peer(input logic g2, input logic au, input logic [3:0] v);
        p_g2 = g2;
        p_auto = au;
        p_req = 1;
        @(negedge core_clk_in) p_req = 0;
        wait_cur(v);
        chk({cur, abwf}, {v, au});
        abw_clr = 1;
        @(negedge core_clk_in) abw_clr = 0;
    endtask
    task automatic t_cfg_fail();
        cfg_spd = SPEED_GEN1;
        cfg_ld = 1;
        @(negedge core_clk_in) cfg_ld = 0;
        chk(tgt, SPEED_GEN1);
        p_inv = 4'ha;
        link_cycle();
        repeat (800) @(negedge core_clk_in);
        chk({cur, inv}, {SPEED_GEN1, 4'ha});
        cfg_spd = SPEED_GEN2;
        cfg_ld = 1;
        @(negedge core_clk_in) cfg_ld = 0;
        p_acc = 0;
        link_cycle();
        repeat (800) @(negedge core_clk_in);
        p_acc = 1;
        repeat (800) @(negedge core_clk_in);
        chk({cur, bwf}, {SPEED_GEN1, 1'b0});
        chk(n_fr, 3);
        // Partner withdraws 5.0: a directed retrain must not ask for it
        p_adv = 0;
        repeat (20) @(negedge core_clk_in);
        rtr = 1;
        @(negedge core_clk_in) rtr = 0;
        repeat (100) @(negedge core_clk_in);
        chk({cur, bwf, lnk.dev_req_gen2}, {SPEED_GEN1, 2'b00});
        p_adv = 1;
        repeat (20) @(negedge core_clk_in);
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge core_clk_in);
        rst_in = 0;
        t_boot();
        t_sw();
        t_peer(1'b0, 1'b1, SPEED_GEN1);
        t_cfg_fail();
        t_peer(1'b1, 1'b0, SPEED_GEN2);
        end_of_test();
    end
endmodule // tb
